// ---- hw/tfcr_cfg.svh ----
/*
 * Constants for the front-end configuration register bank: register indices,
 * writable-bit masks, reset images, field positions and strap bus layout.
 * Assumes it is included by its bare name from the design files.
 */
`ifndef TFCR_CFG_SVH
`define TFCR_CFG_SVH

// -----------------------------------------------------------------------------
// register indices on the serial register port
// -----------------------------------------------------------------------------
`define TFCR_IDX_FAST          3'h0
`define TFCR_IDX_AUX           3'h1
`define TFCR_IDX_RX            3'h2
`define TFCR_IDX_PULSE_AB      3'h3
`define TFCR_IDX_PULSE_CD      3'h4
`define TFCR_IDX_EQ_AB         3'h5
`define TFCR_IDX_EQ_CD         3'h6
`define TFCR_IDX_TX            3'h7
`define TFCR_NUM_REGS          8

// -----------------------------------------------------------------------------
// implemented bits, unimplemented bits read as zero
// -----------------------------------------------------------------------------
`define TFCR_MASK_MODES        8'h7f
`define TFCR_MASK_RX           8'h01
`define TFCR_MASK_FULL         8'hff
`define TFCR_MASK_TX           8'h0f

// -----------------------------------------------------------------------------
// reset images (strap image of all-low pins)
// -----------------------------------------------------------------------------
`define TFCR_RST_FAST          8'h00
`define TFCR_RST_AUX           8'h40
`define TFCR_RST_RX            8'h01
`define TFCR_RST_ZERO          8'h00

// -----------------------------------------------------------------------------
// field positions
// -----------------------------------------------------------------------------
`define TFCR_BIT_EN            6
`define TFCR_MODE_HI           5
`define TFCR_MODE_LO           2
`define TFCR_SEL_HI            1
`define TFCR_SEL_LO            0
`define TFCR_BIT_RX_TERM       0
`define TFCR_TX_BOOST_HI       3
`define TFCR_TX_BOOST_LO       2
`define TFCR_TX_OTERM          1
`define TFCR_TX_DRIVE          0

// -----------------------------------------------------------------------------
// strap bus layout after the synchroniser
// -----------------------------------------------------------------------------
`define TFCR_SP_W              8
`define TFCR_SP_EN             0
`define TFCR_SP_SEL_LO         1
`define TFCR_SP_SEL_HI         2
`define TFCR_SP_EQ             3
`define TFCR_SP_BOOST_LO       4
`define TFCR_SP_BOOST_HI       5
`define TFCR_SP_OTERM          6
`define TFCR_SP_DRIVE          7

// -----------------------------------------------------------------------------
// analog figures reported to the front end
// -----------------------------------------------------------------------------
`define TFCR_DRIVE_LOW_MA      5'h0a
`define TFCR_DRIVE_HIGH_MA     5'h14

`endif

// ---- hw/tfcr_pkg.sv ----
/*
 * Types shared by the front-end configuration register bank.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package tfcr_pkg;

   typedef logic [7:0] tfcr_byte_t;
   typedef logic [2:0] tfcr_idx_t;

   // who governs the registers
   typedef enum logic {
      TFCR_STRAP,
      TFCR_SERIAL
   } tfcr_ctl_e;

endpackage

// ---- hw/tfcr_strap_sync.sv ----
/*
 * Two-flop synchroniser for the static strap pins.
 * Assumes the strap pins are asynchronous to clk_in.
 */
`timescale 1ns/1ps
`include "tfcr_cfg.svh"

module tfcr_strap_sync
   import tfcr_pkg::*;
(
   input  wire logic                    clk_in,
   input  wire logic                    sys_rst_in,
   input  wire logic [`TFCR_SP_W-1:0]   strap_pins_in,
   output logic      [`TFCR_SP_W-1:0]   strap_sync_out
);

   logic [`TFCR_SP_W-1:0] strap_meta;

   // -----------------------------------------------------------------------------
   // synchroniser chain
   // -----------------------------------------------------------------------------
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         strap_meta     <= '0;
         strap_sync_out <= '0;
      end else begin
         strap_meta     <= strap_pins_in;
         strap_sync_out <= strap_meta;
      end
   end

endmodule

// ---- hw/tfcr_fe_decode.sv ----
/*
 * Decodes the register images into registered analog front-end controls.
 * Assumes register images come from logic on clk_in.
 */
`timescale 1ns/1ps
`include "tfcr_cfg.svh"

module tfcr_fe_decode
   import tfcr_pkg::*;
(
   input  wire logic       clk_in,
   input  wire logic       sys_rst_in,
   input  tfcr_byte_t      fast_modes_in,
   input  tfcr_byte_t      aux_modes_in,
   input  tfcr_byte_t      rx_ctl_in,
   input  wire logic [15:0] pulse_bits_in,
   input  wire logic [15:0] eq_bits_in,
   input  tfcr_byte_t      tx_ctl_in,
   output logic            fast_enable_out,
   output logic            standby_out,
   output logic [3:0]      fast_source_out,
   output logic            aux_enable_out,
   output logic [3:0]      aux_source_out,
   output logic            input_term_on_out,
   output logic [15:0]     pulse_lanes_out,
   output logic [3:0]      eq_src_a_out,
   output logic [3:0]      eq_src_b_out,
   output logic [3:0]      eq_src_c_out,
   output logic [3:0]      eq_src_d_out,
   output logic [1:0]      output_boost_level_out,
   output logic [2:0]      output_boost_db_out,
   output logic            output_term_enable_out,
   output logic            output_drive_level_out,
   output logic [4:0]      output_drive_ma_out
);

   // -----------------------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------------------
   // per-lane order {D3..D0, C3..C0, B3..B0, A3..A0}
   function automatic logic [15:0] lane_map(input logic [15:0] v);
      lane_map = {v[12], v[13], v[14], v[15], v[8], v[9], v[10], v[11], v[3:0], v[7:4]};
   endfunction

   function automatic logic [3:0] src_onehot(input logic [1:0] sel);
      src_onehot = 4'h1 << sel;
   endfunction

   logic [15:0] eq_lanes;
   logic [1:0]  boost;
   logic        drive;

   assign eq_lanes = lane_map(eq_bits_in);
   assign boost    = tx_ctl_in[`TFCR_TX_BOOST_HI:`TFCR_TX_BOOST_LO];
   assign drive    = tx_ctl_in[`TFCR_TX_DRIVE];

   // -----------------------------------------------------------------------------
   // registered controls
   // -----------------------------------------------------------------------------
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         fast_enable_out        <= 1'b0;
         standby_out            <= 1'b1;
         fast_source_out        <= 4'h1;
         aux_enable_out         <= 1'b1;
         aux_source_out         <= 4'h1;
         input_term_on_out      <= 1'b1;
         pulse_lanes_out        <= 16'h0000;
         {eq_src_d_out, eq_src_c_out, eq_src_b_out, eq_src_a_out} <= 16'h0000;
         output_boost_level_out <= 2'h0;
         output_boost_db_out    <= 3'h0;
         output_term_enable_out <= 1'b0;
         output_drive_level_out <= 1'b0;
         output_drive_ma_out    <= `TFCR_DRIVE_LOW_MA;
      end else begin
         fast_enable_out        <= fast_modes_in[`TFCR_BIT_EN];
         standby_out            <= ~fast_modes_in[`TFCR_BIT_EN];
         fast_source_out        <= src_onehot(fast_modes_in[`TFCR_SEL_HI:`TFCR_SEL_LO]);
         aux_enable_out         <= aux_modes_in[`TFCR_BIT_EN];
         aux_source_out         <= src_onehot(aux_modes_in[`TFCR_SEL_HI:`TFCR_SEL_LO]);
         input_term_on_out      <= rx_ctl_in[`TFCR_BIT_RX_TERM];
         pulse_lanes_out        <= lane_map(pulse_bits_in);
         {eq_src_d_out, eq_src_c_out, eq_src_b_out, eq_src_a_out} <= eq_lanes;
         output_boost_level_out <= boost;
         output_boost_db_out    <= {boost, 1'b0};
         output_term_enable_out <= tx_ctl_in[`TFCR_TX_OTERM];
         output_drive_level_out <= drive;
         output_drive_ma_out    <= drive ? `TFCR_DRIVE_HIGH_MA : `TFCR_DRIVE_LOW_MA;
      end
   end

   // -----------------------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------------------
   AST_EQ_MAP: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      1'b1 |=> (eq_src_c_out[3] == $past(eq_bits_in[8])) && (eq_src_d_out[0] == $past(eq_bits_in[15]))
            && (eq_src_a_out == $past(eq_bits_in[7:4])) && (eq_src_b_out == $past(eq_bits_in[3:0])))
      else $error("equalizer lane map wrong");
   AST_BOOST_DB: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (boost == 2'h3) |=> (output_boost_db_out == 3'h6))
      else $error("pre-emphasis code 11 not 6 dB");
   AST_DRIVE_MA: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      !drive |=> (output_drive_ma_out == 5'h0a))
      else $error("drive bit 0 not 10 mA");
   AST_STANDBY: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      !fast_modes_in[`TFCR_BIT_EN] |=> standby_out && !fast_enable_out)
      else $error("enable low did not give standby");

endmodule

// ---- hw/tfcr_config_regs.sv ----
/*
 * Front-end configuration register bank for a four-source video link switch:
 * eight byte registers reached through the serial control register port,
 * loaded from strap pins after reset until the first serial access, and
 * decoded into analog front-end controls.
 * Assumes the serial interface delivers one-cycle access strobes on clk_in;
 * strap pins are asynchronous and static.
 */
`timescale 1ns/1ps
`include "tfcr_cfg.svh"

module tfcr_config_regs
   import tfcr_pkg::*;
(
   input  wire logic       clk_in,
   input  wire logic       sys_rst_in,
   // serial control register port
   input  wire logic       ser_access_in,
   input  wire logic       ser_write_in,
   input  tfcr_idx_t       ser_addr_in,
   input  tfcr_byte_t      ser_wdata_in,
   output tfcr_byte_t      ser_rdata_out,
   output logic            ser_rvalid_out,
   // strap pins
   input  wire logic       strap_fast_enable_in,
   input  wire logic [1:0] strap_source_select_in,
   input  wire logic       strap_eq_level_in,
   input  wire logic [1:0] strap_boost_level_in,
   input  wire logic       strap_out_term_in,
   input  wire logic       strap_drive_level_in,
   // status
   output logic            strap_active_out,
   // front-end controls
   output logic            fast_enable_out,
   output logic            standby_out,
   output logic [3:0]      fast_source_out,
   output logic            aux_enable_out,
   output logic [3:0]      aux_source_out,
   output logic            input_term_on_out,
   output logic [15:0]     pulse_lanes_out,
   output logic [3:0]      eq_src_a_out,
   output logic [3:0]      eq_src_b_out,
   output logic [3:0]      eq_src_c_out,
   output logic [3:0]      eq_src_d_out,
   output logic [1:0]      output_boost_level_out,
   output logic [2:0]      output_boost_db_out,
   output logic            output_term_enable_out,
   output logic            output_drive_level_out,
   output logic [4:0]      output_drive_ma_out
);

   // -----------------------------------------------------------------------------
   // state
   // -----------------------------------------------------------------------------
   tfcr_ctl_e             ctl_state;
   tfcr_ctl_e             next_ctl_state;
   tfcr_byte_t            regs      [`TFCR_NUM_REGS];
   tfcr_byte_t            next_regs [`TFCR_NUM_REGS];
   logic [`TFCR_SP_W-1:0] strap_pins;
   logic [`TFCR_SP_W-1:0] strap_sync;

   // -----------------------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------------------
   function automatic tfcr_byte_t reg_mask(input tfcr_idx_t idx);
      case (idx)
         `TFCR_IDX_FAST: reg_mask = `TFCR_MASK_MODES;
         `TFCR_IDX_AUX:  reg_mask = `TFCR_MASK_MODES;
         `TFCR_IDX_RX:   reg_mask = `TFCR_MASK_RX;
         `TFCR_IDX_TX:   reg_mask = `TFCR_MASK_TX;
         default:        reg_mask = `TFCR_MASK_FULL;
      endcase
   endfunction

   // register image that the strap pins impose
   function automatic tfcr_byte_t strap_image(input tfcr_idx_t idx,
                                              input logic [`TFCR_SP_W-1:0] sp);
      tfcr_byte_t img;
      img = `TFCR_RST_ZERO;
      case (idx)
         `TFCR_IDX_FAST: begin
            img[`TFCR_BIT_EN]             = sp[`TFCR_SP_EN];
            img[`TFCR_SEL_HI:`TFCR_SEL_LO] = sp[`TFCR_SP_SEL_HI:`TFCR_SP_SEL_LO];
         end
         `TFCR_IDX_AUX: begin
            img[`TFCR_BIT_EN]             = 1'b1;
            img[`TFCR_SEL_HI:`TFCR_SEL_LO] = sp[`TFCR_SP_SEL_HI:`TFCR_SP_SEL_LO];
         end
         `TFCR_IDX_RX: begin
            img[`TFCR_BIT_RX_TERM] = 1'b1;
         end
         `TFCR_IDX_EQ_AB, `TFCR_IDX_EQ_CD: begin
            img = {8{sp[`TFCR_SP_EQ]}};
         end
         `TFCR_IDX_TX: begin
            img[`TFCR_TX_BOOST_HI:`TFCR_TX_BOOST_LO] = sp[`TFCR_SP_BOOST_HI:`TFCR_SP_BOOST_LO];
            img[`TFCR_TX_OTERM] = sp[`TFCR_SP_OTERM];
            img[`TFCR_TX_DRIVE] = sp[`TFCR_SP_DRIVE];
         end
         default: begin
            img = `TFCR_RST_ZERO;
         end
      endcase
      strap_image = img;
   endfunction

   // -----------------------------------------------------------------------------
   // strap pins through the synchroniser
   // -----------------------------------------------------------------------------
   assign strap_pins[`TFCR_SP_EN]                        = strap_fast_enable_in;
   assign strap_pins[`TFCR_SP_SEL_HI:`TFCR_SP_SEL_LO]     = strap_source_select_in;
   assign strap_pins[`TFCR_SP_EQ]                        = strap_eq_level_in;
   assign strap_pins[`TFCR_SP_BOOST_HI:`TFCR_SP_BOOST_LO] = strap_boost_level_in;
   assign strap_pins[`TFCR_SP_OTERM]                     = strap_out_term_in;
   assign strap_pins[`TFCR_SP_DRIVE]                     = strap_drive_level_in;

   tfcr_strap_sync u_strap_sync (
      .clk_in         (clk_in),
      .sys_rst_in     (sys_rst_in),
      .strap_pins_in  (strap_pins),
      .strap_sync_out (strap_sync)
   );

   // -----------------------------------------------------------------------------
   // control path and access decode
   // -----------------------------------------------------------------------------
   logic       wr_hit;
   logic       rd_hit;
   logic       in_strap;
   tfcr_byte_t rd_word;

   assign wr_hit         = ser_access_in & ser_write_in;
   assign rd_hit         = ser_access_in & ~ser_write_in;
   assign in_strap       = (ctl_state == TFCR_STRAP);
   assign rd_word        = regs[ser_addr_in];
   assign next_ctl_state = (in_strap && ser_access_in) ? TFCR_SERIAL : ctl_state;

   always_comb begin
      for (int i = 0; i < `TFCR_NUM_REGS; i++) begin
         if (wr_hit && (ser_addr_in == tfcr_idx_t'(i))) begin
            next_regs[i] = ser_wdata_in & reg_mask(tfcr_idx_t'(i));
         end else if (in_strap && !ser_access_in) begin
            next_regs[i] = strap_image(tfcr_idx_t'(i), strap_sync);
         end else begin
            next_regs[i] = regs[i];
         end
      end
   end

   // -----------------------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------------------
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         ctl_state <= TFCR_STRAP;
      end else begin
         ctl_state <= next_ctl_state;
      end
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         regs[`TFCR_IDX_FAST]     <= `TFCR_RST_FAST;
         regs[`TFCR_IDX_AUX]      <= `TFCR_RST_AUX;
         regs[`TFCR_IDX_RX]       <= `TFCR_RST_RX;
         regs[`TFCR_IDX_PULSE_AB] <= `TFCR_RST_ZERO;
         regs[`TFCR_IDX_PULSE_CD] <= `TFCR_RST_ZERO;
         regs[`TFCR_IDX_EQ_AB]    <= `TFCR_RST_ZERO;
         regs[`TFCR_IDX_EQ_CD]    <= `TFCR_RST_ZERO;
         regs[`TFCR_IDX_TX]       <= `TFCR_RST_ZERO;
      end else begin
         regs <= next_regs;
      end
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         ser_rdata_out  <= `TFCR_RST_ZERO;
         ser_rvalid_out <= 1'b0;
      end else begin
         ser_rvalid_out <= rd_hit;
         if (rd_hit) begin
            ser_rdata_out <= rd_word;
         end
      end
   end

   assign strap_active_out = in_strap;

   // -----------------------------------------------------------------------------
   // front-end decode
   // -----------------------------------------------------------------------------
   tfcr_fe_decode u_fe_decode (
      .clk_in                 (clk_in),
      .sys_rst_in             (sys_rst_in),
      .fast_modes_in          (regs[`TFCR_IDX_FAST]),
      .aux_modes_in           (regs[`TFCR_IDX_AUX]),
      .rx_ctl_in              (regs[`TFCR_IDX_RX]),
      .pulse_bits_in          ({regs[`TFCR_IDX_PULSE_CD], regs[`TFCR_IDX_PULSE_AB]}),
      .eq_bits_in             ({regs[`TFCR_IDX_EQ_CD], regs[`TFCR_IDX_EQ_AB]}),
      .tx_ctl_in              (regs[`TFCR_IDX_TX]),
      .fast_enable_out        (fast_enable_out),
      .standby_out            (standby_out),
      .fast_source_out        (fast_source_out),
      .aux_enable_out         (aux_enable_out),
      .aux_source_out         (aux_source_out),
      .input_term_on_out      (input_term_on_out),
      .pulse_lanes_out        (pulse_lanes_out),
      .eq_src_a_out           (eq_src_a_out),
      .eq_src_b_out           (eq_src_b_out),
      .eq_src_c_out           (eq_src_c_out),
      .eq_src_d_out           (eq_src_d_out),
      .output_boost_level_out (output_boost_level_out),
      .output_boost_db_out    (output_boost_db_out),
      .output_term_enable_out (output_term_enable_out),
      .output_drive_level_out (output_drive_level_out),
      .output_drive_ma_out    (output_drive_ma_out)
   );

   // -----------------------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------------------
   logic [63:0] regs_flat;
   assign regs_flat = {regs[7], regs[6], regs[5], regs[4], regs[3], regs[2], regs[1], regs[0]};

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);

   sequence seq_strap_idle;
      in_strap && !ser_access_in;
   endsequence

   sequence seq_first_access;
      in_strap ##0 ser_access_in;
   endsequence

   AST_FAST_IMAGE: assert property (
      seq_strap_idle |=> regs[`TFCR_IDX_FAST] ==
         {1'b0, $past(strap_sync[`TFCR_SP_EN]), 4'h0, $past(strap_sync[2:1])})
      else $error("strap fast mode image wrong");

   AST_AUX_IMAGE: assert property (
      seq_strap_idle |=> regs[`TFCR_IDX_AUX] == {2'b01, 4'h0, $past(strap_sync[2:1])})
      else $error("strap aux mode image wrong");

   AST_TERM_IMAGE: assert property (
      seq_strap_idle |=> (regs[`TFCR_IDX_PULSE_AB] == 8'h00) && (regs[`TFCR_IDX_PULSE_CD] == 8'h00)
                         && (regs[`TFCR_IDX_RX] == 8'h01))
      else $error("strap termination image wrong");

   AST_EQ_COPY: assert property (
      seq_strap_idle |=> {regs[`TFCR_IDX_EQ_CD], regs[`TFCR_IDX_EQ_AB]} ==
         {16{$past(strap_sync[`TFCR_SP_EQ])}})
      else $error("strap equalizer copy wrong");

   AST_TX_IMAGE: assert property (
      seq_strap_idle |=> regs[`TFCR_IDX_TX] == {4'h0, $past(strap_sync[5:4]),
         $past(strap_sync[`TFCR_SP_OTERM]), $past(strap_sync[`TFCR_SP_DRIVE])})
      else $error("strap transmitter image wrong");

   AST_LOCK_ENTER: assert property (
      seq_first_access |=> !in_strap && !strap_active_out)
      else $error("first serial access did not end strap mode");

   AST_LOCK_HOLD: assert property (
      !in_strap |=> !in_strap [*2])
      else $error("strap mode came back after serial access");

   AST_STRAP_IGNORED: assert property (
      (!in_strap && !wr_hit) |=> $stable(regs_flat))
      else $error("registers changed without a serial write");

   AST_WRITE_TAKES: assert property (
      wr_hit |=> regs[$past(ser_addr_in)] == ($past(ser_wdata_in) & reg_mask($past(ser_addr_in))))
      else $error("serial write not stored");

   AST_READ_BACK: assert property (
      rd_hit |=> ser_rvalid_out && (ser_rdata_out == $past(rd_word)))
      else $error("serial read data wrong");

   sequence seq_strap_settle;
      seq_strap_idle ##1 1'b1;
   endsequence

   sequence seq_first_read;
      seq_first_access ##0 !ser_write_in;
   endsequence

   AST_FIRST_READ: assert property (
      seq_first_read |=> $stable(regs_flat))
      else $error("first serial read changed a register");

   AST_STRAP_TERM_OUT: assert property (
      seq_strap_settle |=> input_term_on_out && (pulse_lanes_out == 16'h0000))
      else $error("strap termination outputs wrong");

   AST_STRAP_AUX_OUT: assert property (
      seq_strap_settle |=> aux_enable_out)
      else $error("strap mode left the aux switch off");

   AST_FAST_SRC: assert property (
      1'b1 |=> $onehot(fast_source_out)
         && fast_source_out[$past(regs[`TFCR_IDX_FAST][`TFCR_SEL_HI:`TFCR_SEL_LO])])
      else $error("fast source decode wrong");

   AST_AUX_SRC: assert property (
      1'b1 |=> $onehot(aux_source_out)
         && aux_source_out[$past(regs[`TFCR_IDX_AUX][`TFCR_SEL_HI:`TFCR_SEL_LO])])
      else $error("aux source decode wrong");

   AST_OUT_TERM: assert property (
      1'b1 |=> output_term_enable_out == $past(regs[`TFCR_IDX_TX][`TFCR_TX_OTERM]))
      else $error("output termination decode wrong");

   AST_DRIVE_HIGH: assert property (
      regs[`TFCR_IDX_TX][`TFCR_TX_DRIVE] |=> (output_drive_ma_out == `TFCR_DRIVE_HIGH_MA))
      else $error("drive bit 1 not 20 mA");

   AST_BOOST_LOW: assert property (
      (regs[`TFCR_IDX_TX][`TFCR_TX_BOOST_HI:`TFCR_TX_BOOST_LO] == 2'h1)
         |=> (output_boost_db_out == 3'h2))
      else $error("pre-emphasis code 01 not 2 dB");

   AST_ENABLE_ON: assert property (
      regs[`TFCR_IDX_FAST][`TFCR_BIT_EN] |=> fast_enable_out && !standby_out)
      else $error("enable high did not switch channels on");

   AST_EQ_C0: assert property (
      1'b1 |=> eq_src_c_out[0] == $past(regs[`TFCR_IDX_EQ_CD][3]))
      else $error("equalizer bit 11 not on source C lane 0");

endmodule

// ---- verification/tfcr_strap_model.sv ----
/* board strap model: static strap pin levels taken from one packed word.
   assumes the bench changes the word only at clock edges. */
`timescale 1ns/1ps
module tfcr_strap_model (
   input  wire logic [7:0] strap_word_in,
   output logic            en_out,
   output logic [1:0]      sel_out,
   output logic            eq_out,
   output logic [1:0]      boost_out,
   output logic            term_out,
   output logic            drive_out
);
   // each pin is a hard logic 1 or logic 0
   assign {drive_out, term_out, boost_out, eq_out, sel_out, en_out} = strap_word_in;
endmodule

// ---- verification/tb.sv ----
/* self-checking bench for the config register bank.
   assumes a 40 MHz clock and the strap model beside the design. */
`timescale 1ns/1ps
`include "tfcr_cfg.svh"
`define CHK(n,e,g) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb
   import tfcr_pkg::*;
;
   logic clk_in = 0, sys_rst_in = 1, acc = 0, wr = 0;
   tfcr_idx_t  addr = '0;
   tfcr_byte_t wd = '0, sw = '0, ev, rdata;
   tfcr_byte_t v[8];
   tfcr_byte_t mk[8] = '{8'h7f, 8'h7f, 8'h01, 8'hff, 8'hff, 8'hff, 8'hff, 8'h0f};
   tfcr_byte_t expq[$];
   int n_errors = 0, total_checks = 0;
   logic rv, act, fen, sby, aen, it, ot, od, p_en, p_eq, p_ot, p_dr;
   logic [1:0] p_sel, p_bs, obl;
   logic [3:0] fs, as, ea, eb, ec, ed;
   logic [15:0] pl;
   logic [2:0] odb;
   logic [4:0] oma;
   tfcr_strap_model tfcr_strap_model_inst (.strap_word_in(sw), .en_out(p_en), .sel_out(p_sel),
      .eq_out(p_eq), .boost_out(p_bs), .term_out(p_ot), .drive_out(p_dr));
   tfcr_config_regs tfcr_config_regs_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .ser_access_in(acc), .ser_write_in(wr), .ser_addr_in(addr), .ser_wdata_in(wd),
      .ser_rdata_out(rdata), .ser_rvalid_out(rv), .strap_fast_enable_in(p_en),
      .strap_source_select_in(p_sel), .strap_eq_level_in(p_eq), .strap_boost_level_in(p_bs),
      .strap_out_term_in(p_ot), .strap_drive_level_in(p_dr), .strap_active_out(act),
      .fast_enable_out(fen), .standby_out(sby), .fast_source_out(fs), .aux_enable_out(aen),
      .aux_source_out(as), .input_term_on_out(it), .pulse_lanes_out(pl), .eq_src_a_out(ea),
      .eq_src_b_out(eb), .eq_src_c_out(ec), .eq_src_d_out(ed), .output_boost_level_out(obl),
      .output_boost_db_out(odb), .output_term_enable_out(ot), .output_drive_level_out(od),
      .output_drive_ma_out(oma));
   // -----------------------------------------------------------------
   // tasks
   // -----------------------------------------------------------------
   task automatic stop_test;
      if (n_errors == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic acc_t(input logic w, input tfcr_idx_t a, input tfcr_byte_t d, e);
      @(posedge clk_in);
      acc <= 1;
      wr <= w;
      addr <= a;
      wd <= d;
      if (!w) expq.push_back(e);
      @(posedge clk_in);
      acc <= 0;
   endtask
   task automatic chk_out(input tfcr_byte_t f, a, r, e1, e2, t);
      tfcr_byte_t rvs;
      rvs = {<<{e2}};
      `CHK("fen", f[6], fen)
      `CHK("sby", ~f[6], sby)
      `CHK("fsrc", 4'h1 << f[1:0], fs)
      `CHK("aen", a[6], aen)
      `CHK("asrc", 4'h1 << a[1:0], as)
      `CHK("iterm", r[0], it)
      `CHK("eqab", e1, {ea, eb})
      `CHK("eqcd", rvs, {ec, ed})
      `CHK("bst", t[3:2], obl)
      `CHK("bdb", {t[3:2], 1'b0}, odb)
      `CHK("oterm", t[1], ot)
      `CHK("odrv", t[0], od)
      `CHK("oma", t[0] ? 5'h14 : 5'h0a, oma)
   endtask
   task automatic strap_chk(input tfcr_byte_t s);
      chk_out({1'b0, s[0], 4'h0, s[2:1]}, {6'h10, s[2:1]}, 8'h01, {8{s[3]}}, {8{s[3]}},
         {4'h0, s[5:4], s[6], s[7]});
   endtask
   // -----------------------------------------------------------------
   // clock, read monitor, watchdog, main sequence
   // -----------------------------------------------------------------
   initial forever #12.5 clk_in = ~clk_in;
   always @(posedge clk_in) if (rv === 1'b1) begin
      ev = expq.pop_front();
      `CHK("rdata", ev, rdata)
   end
   initial begin
      #20000;
      n_errors++;
      stop_test();
   end
   initial begin
      tfcr_byte_t o, pr;
      void'($urandom(32'h7667));
      repeat (5) @(posedge clk_in);
      sys_rst_in <= 0;
      for (int i = 0; i < 6; i++) begin
         @(posedge clk_in);
         sw <= $urandom;
         repeat (5) @(posedge clk_in);
         @(negedge clk_in);
         `CHK("act", 1'b1, act)
         `CHK("pulse", 16'h0000, pl)
         strap_chk(sw);
      end
      o = sw;
      acc_t(0, `TFCR_IDX_FAST, 8'h00, {1'b0, o[0], 4'h0, o[2:1]});
      @(posedge clk_in);
      sw <= ~o;
      repeat (6) @(posedge clk_in);
      @(negedge clk_in);
      `CHK("act", 1'b0, act)
      strap_chk(o);
      repeat (3) begin
         for (int i = 0; i < 8; i++) begin
            v[i] = $urandom;
            acc_t(1, i[2:0], v[i], 8'h00);
         end
         for (int i = 0; i < 8; i++) acc_t(0, i[2:0], 8'h00, v[i] & mk[i]);
         repeat (3) @(posedge clk_in);
         @(negedge clk_in);
         chk_out(v[0] & mk[0], v[1] & mk[1], v[2] & mk[2], v[5], v[6], v[7] & mk[7]);
         pr = {<<{v[4]}};
         `CHK("plane", {pr[3:0], pr[7:4], v[3][3:0], v[3][7:4]}, pl)
      end
      @(posedge clk_in);
      sys_rst_in <= 1;
      repeat (2) @(posedge clk_in);
      sys_rst_in <= 0;
      repeat (6) @(posedge clk_in);
      @(negedge clk_in);
      `CHK("act", 1'b1, act)
      strap_chk(sw);
      stop_test();
   end
endmodule
